// >>> logic/feature_pkg.sv
// Operation
// - byte-wide transfer option enabled makes the data path use only lines 7..0.
// - 02h enables write cache; 82h disables it, flushing before completion.
// - for 03h the selection byte splits into type bits 7:3, mode 2:0.
// - type 00001b pio flow, 00100b multiword dma, 01000b ultra dma; 00010b/10000b unusable.
// - 00h selects default pio; 01h also turns IORDY off when supported.
// - every mode number up to the supported maximum is accepted.
// - pio mode 3 or higher always runs with IORDY flow control.
// - enabling one dma family disables the other; one family at most.
// - 05h enables power management with level in selection byte; 85h disables.
// - level FEh max performance, 80h-FDh no spin-down, 01h-7Fh standby; 00h/FFh reserved.
// - 06h enables power-up-in-standby; kept through hardware and software reset.
// - 86h disables power-up-in-standby; disabled is the factory default.
// - 07h moves a device that powered up in standby to active.
// - 0Ah selects high power; restored on hardware reset, and on software reset unless reverting is off.
// - 8Ah selects low power; only allowed commands run, others abort.
// - 31h disables notification and unlocks media; no effect if already off.
// - 95h enables notification, clears lock, returns version in notify_version.
// - capability byte: bit0 prior enable, bit1 lock, bit2 powered eject, rest zero.
// - AAh enables read look-ahead, 55h disables it.
// - 5Dh/DDh release interrupt enable; 5Eh/DEh service interrupt enable.
// - CCh enables reverting to defaults; 66h keeps settings over software reset.
// - unsupported or invalid input aborts: abort and error set, busy cleared.
// - power-on reset loads default values for all settings; hardware reset for all but power-up-in-standby.
package feature_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_FEATURES = 8'h00;
   localparam logic [7:0] ADDR_SECTOR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_COMMAND = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_VERSION = 8'h10;
   localparam logic [7:0] ADDR_CAPABILITY = 8'h14;
   localparam logic [7:0] ADDR_STATE = 8'h18;
   localparam logic [7:0] ADDR_XFER = 8'h1C;
   localparam logic [7:0] ADDR_APM = 8'h20;
   localparam logic [7:0] ADDR_RESET_CTRL = 8'h24;
   // command and subcommand codes
   localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
   localparam logic [7:0] SUB_BYTE_ON = 8'h01;
   localparam logic [7:0] SUB_BYTE_OFF = 8'h81;
   localparam logic [7:0] SUB_WC_ON = 8'h02;
   localparam logic [7:0] SUB_WC_OFF = 8'h82;
   localparam logic [7:0] SUB_XFER = 8'h03;
   localparam logic [7:0] SUB_APM_ON = 8'h05;
   localparam logic [7:0] SUB_APM_OFF = 8'h85;
   localparam logic [7:0] SUB_PUIS_ON = 8'h06;
   localparam logic [7:0] SUB_PUIS_OFF = 8'h86;
   localparam logic [7:0] SUB_SPINUP = 8'h07;
   localparam logic [7:0] SUB_HIPWR = 8'h0A;
   localparam logic [7:0] SUB_LOPWR = 8'h8A;
   localparam logic [7:0] SUB_MSN_OFF = 8'h31;
   localparam logic [7:0] SUB_MSN_ON = 8'h95;
   localparam logic [7:0] SUB_RLA_ON = 8'hAA;
   localparam logic [7:0] SUB_RLA_OFF = 8'h55;
   localparam logic [7:0] SUB_REL_ON = 8'h5D;
   localparam logic [7:0] SUB_REL_OFF = 8'hDD;
   localparam logic [7:0] SUB_SVC_ON = 8'h5E;
   localparam logic [7:0] SUB_SVC_OFF = 8'hDE;
   localparam logic [7:0] SUB_REVERT_ON = 8'hCC;
   localparam logic [7:0] SUB_REVERT_OFF = 8'h66;
   // transfer types and limits
   localparam logic [4:0] XT_DEFAULT = 5'h00;
   localparam logic [4:0] XT_PIO = 5'h01;
   localparam logic [4:0] XT_MWDMA = 5'h04;
   localparam logic [4:0] XT_UDMA = 5'h08;
   localparam logic [2:0] NUM_DEFAULT = 3'h0;
   localparam logic [2:0] NUM_NO_IORDY = 3'h1;
   localparam logic [2:0] PIO_IORDY_MIN = 3'h3;
   localparam logic [2:0] MAX_PIO = 3'h4;
   localparam logic [2:0] MAX_MWDMA = 3'h2;
   localparam logic [2:0] MAX_UDMA = 3'h5;
   localparam logic IORDY_OFF_SUPPORTED = 1'b1;
   localparam logic APM_OFF_SUPPORTED = 1'b1;
   // power management levels
   localparam logic [7:0] APM_RSVD_LO = 8'h00;
   localparam logic [7:0] APM_RSVD_HI = 8'hFF;
   localparam logic [7:0] APM_NO_SPINDOWN = 8'h80;
   // media notification
   localparam logic [7:0] NOTIFY_VERSION = 8'h00;
   localparam logic LOCK_CAPABLE = 1'b1;
   localparam logic EJECT_CAPABLE = 1'b0;
   // dma families
   localparam logic [1:0] FAM_NONE = 2'h0;
   localparam logic [1:0] FAM_MWDMA = 2'h1;
   localparam logic [1:0] FAM_UDMA = 2'h2;
   // defaults after power-on or hardware reset
   localparam logic DEF_WC = 1'b1;
   localparam logic DEF_RLA = 1'b1;
   localparam logic DEF_REVERT = 1'b1;
   localparam logic [7:0] DEF_APM = 8'hFE;
   // status and reset control bit positions
   localparam int ST_ERR = 0;
   localparam int ST_DRQ = 3;
   localparam int ST_ABRT = 4;
   localparam int ST_DRDY = 6;
   localparam int ST_BSY = 7;
   localparam int RC_SOFT = 0;
   localparam int RC_HARD = 1;
endpackage

// >>> logic/set_features_unit.sv
`timescale 1ns/10ps
`default_nettype none
module set_features_unit (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cache flush handshake
   output logic flush_req,
   input wire logic flush_done,
   // feature state seen by the rest of the device
   output logic byte_mode,
   output logic write_cache_en,
   output logic iordy_active,
   output logic [2:0] pio_mode,
   output logic [1:0] dma_family,
   output logic [2:0] dma_mode,
   output logic apm_en,
   output logic apm_standby_ok,
   output logic in_standby,
   output logic low_power,
   output logic notify_en,
   output logic media_locked,
   output logic look_ahead_en,
   output logic release_irq_en,
   output logic service_irq_en
);
   typedef enum logic [2:0] {S_IDLE = 3'b001, S_EXEC = 3'b010, S_FLUSH = 3'b100} state_e;
   state_e state;
   logic [7:0] features, sector_count, last_cmd, notify_version, notify_capability, apm_level;
   logic err, abrt, iordy_off, puis_en, revert_en, rd_done;
   logic [31:0] next_prdata;

   // mode numbers at or below the maximum are all valid
   function automatic logic mode_ok(input logic [4:0] t, input logic [2:0] n);
      case (t)
         feature_pkg::XT_DEFAULT: mode_ok = (n == feature_pkg::NUM_DEFAULT) ||
            (n == feature_pkg::NUM_NO_IORDY && feature_pkg::IORDY_OFF_SUPPORTED);
         feature_pkg::XT_PIO: mode_ok = (n <= feature_pkg::MAX_PIO);
         feature_pkg::XT_MWDMA: mode_ok = (n <= feature_pkg::MAX_MWDMA);
         feature_pkg::XT_UDMA: mode_ok = (n <= feature_pkg::MAX_UDMA);
         default: mode_ok = 1'b0;
      endcase
   endfunction

   // apb decode
   wire logic access = psel && penable;
   wire logic done = access && rd_done;
   wire logic wr_done = done && pwrite;
   wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= feature_pkg::ADDR_RESET_CTRL);
   wire logic busy = (state != S_IDLE);
   wire logic wr_cmd = wr_done && (paddr == feature_pkg::ADDR_COMMAND) && !busy;
   wire logic wr_rst = wr_done && (paddr == feature_pkg::ADDR_RESET_CTRL);
   wire logic soft_rst = wr_rst && pwdata[feature_pkg::RC_SOFT];
   wire logic hard_rst = wr_rst && pwdata[feature_pkg::RC_HARD];
   // busy blocks host writes to the input bytes as in a real task file
   wire logic wr_feat = wr_done && (paddr == feature_pkg::ADDR_FEATURES) && !busy;
   wire logic wr_sc = wr_done && (paddr == feature_pkg::ADDR_SECTOR_COUNT) && !busy;

   // subcommand decode
   wire logic [4:0] xfer_type = sector_count[7:3];
   wire logic [2:0] xfer_num = sector_count[2:0];
   wire logic xfer_good = mode_ok(xfer_type, xfer_num);
   wire logic apm_good = (sector_count != feature_pkg::APM_RSVD_LO) &&
      (sector_count != feature_pkg::APM_RSVD_HI);
   wire logic pwr_sub = (features == feature_pkg::SUB_HIPWR) || (features == feature_pkg::SUB_LOPWR);
   wire logic known_sub = (features == feature_pkg::SUB_BYTE_ON) || (features == feature_pkg::SUB_BYTE_OFF) ||
      (features == feature_pkg::SUB_WC_ON) || (features == feature_pkg::SUB_WC_OFF) ||
      (features == feature_pkg::SUB_XFER) || (features == feature_pkg::SUB_APM_ON) ||
      (features == feature_pkg::SUB_APM_OFF && feature_pkg::APM_OFF_SUPPORTED) ||
      (features == feature_pkg::SUB_PUIS_ON) || (features == feature_pkg::SUB_PUIS_OFF) ||
      (features == feature_pkg::SUB_SPINUP) || pwr_sub ||
      (features == feature_pkg::SUB_MSN_OFF) || (features == feature_pkg::SUB_MSN_ON) ||
      (features == feature_pkg::SUB_RLA_ON) || (features == feature_pkg::SUB_RLA_OFF) ||
      (features == feature_pkg::SUB_REL_ON) || (features == feature_pkg::SUB_REL_OFF) ||
      (features == feature_pkg::SUB_SVC_ON) || (features == feature_pkg::SUB_SVC_OFF) ||
      (features == feature_pkg::SUB_REVERT_ON) || (features == feature_pkg::SUB_REVERT_OFF);
   // low power accepts only the two power subcommands here
   wire logic bad = (last_cmd != feature_pkg::CMD_SET_FEATURES) || !known_sub ||
      (low_power && !pwr_sub) ||
      (features == feature_pkg::SUB_XFER && !xfer_good) ||
      (features == feature_pkg::SUB_APM_ON && !apm_good);
   wire logic exec_ok = (state == S_EXEC) && !bad;
   wire logic exec_bad = (state == S_EXEC) && bad;
   wire logic set_xfer = exec_ok && (features == feature_pkg::SUB_XFER);

   // apb answer: one wait state so read data comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_done <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         rd_done <= access && !rd_done;
         prdata <= (access && !rd_done && !pwrite) ? next_prdata : prdata;
         pslverr <= access && !rd_done && !mapped;
      end
   end
   assign pready = rd_done;

   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         feature_pkg::ADDR_FEATURES: next_prdata[7:0] = features;
         feature_pkg::ADDR_SECTOR_COUNT: next_prdata[7:0] = sector_count;
         feature_pkg::ADDR_COMMAND: next_prdata[7:0] = last_cmd;
         feature_pkg::ADDR_STATUS: begin
            next_prdata[feature_pkg::ST_ERR] = err;
            next_prdata[feature_pkg::ST_ABRT] = abrt;
            next_prdata[feature_pkg::ST_DRDY] = !busy;
            next_prdata[feature_pkg::ST_BSY] = busy;
         end
         feature_pkg::ADDR_VERSION: next_prdata[7:0] = notify_version;
         feature_pkg::ADDR_CAPABILITY: next_prdata[7:0] = notify_capability;
         feature_pkg::ADDR_STATE: next_prdata[15:0] = {puis_en, revert_en, iordy_off, byte_mode,
            write_cache_en, apm_en, in_standby, low_power, notify_en, media_locked,
            look_ahead_en, release_irq_en, service_irq_en, iordy_active, flush_req, 1'b0};
         feature_pkg::ADDR_XFER: next_prdata[7:0] = {dma_family, dma_mode, pio_mode};
         feature_pkg::ADDR_APM: next_prdata[7:0] = apm_level;
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // host input bytes and command sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         features <= 8'h00;
         sector_count <= 8'h00;
         last_cmd <= 8'h00;
         state <= S_IDLE;
         err <= 1'b0;
         abrt <= 1'b0;
         flush_req <= 1'b0;
      end else begin
         if (wr_feat) features <= pwdata[7:0];
         if (wr_sc) sector_count <= pwdata[7:0];
         if (wr_cmd) last_cmd <= pwdata[7:0];
         case (state)
            S_IDLE: begin
               if (wr_cmd) begin
                  state <= S_EXEC;
                  err <= 1'b0;
                  abrt <= 1'b0;
               end
            end
            S_EXEC: begin
               if (bad) begin
                  err <= 1'b1;
                  abrt <= 1'b1;
                  state <= S_IDLE;
               end else if (features == feature_pkg::SUB_WC_OFF) begin
                  flush_req <= 1'b1;
                  state <= S_FLUSH;
               end else begin
                  state <= S_IDLE;
               end
            end
            S_FLUSH: begin
               // completion waits for the flush to finish
               if (flush_done) begin
                  flush_req <= 1'b0;
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
         if (hard_rst || soft_rst) begin
            // a reset abandons a flush in flight; the cache owner sees req drop
            state <= S_IDLE;
            flush_req <= 1'b0;
         end
      end
   end

   // persistent and resettable feature state
   wire logic revert_now = hard_rst || (soft_rst && revert_en);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         puis_en <= 1'b0;
         in_standby <= 1'b0;
      end else if (hard_rst || soft_rst) begin
         in_standby <= hard_rst ? puis_en : in_standby;
      end else if (exec_ok) begin
         case (features)
            feature_pkg::SUB_PUIS_ON: puis_en <= 1'b1;
            feature_pkg::SUB_PUIS_OFF: puis_en <= 1'b0;
            feature_pkg::SUB_SPINUP: in_standby <= 1'b0;
            default: puis_en <= puis_en;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_mode <= 1'b0;
         write_cache_en <= feature_pkg::DEF_WC;
         apm_en <= 1'b0;
         apm_level <= feature_pkg::DEF_APM;
         low_power <= 1'b0;
         notify_en <= 1'b0;
         media_locked <= 1'b0;
         look_ahead_en <= feature_pkg::DEF_RLA;
         release_irq_en <= 1'b0;
         service_irq_en <= 1'b0;
         revert_en <= feature_pkg::DEF_REVERT;
      end else if (revert_now) begin
         byte_mode <= 1'b0;
         write_cache_en <= feature_pkg::DEF_WC;
         apm_en <= 1'b0;
         apm_level <= feature_pkg::DEF_APM;
         low_power <= 1'b0;
         notify_en <= 1'b0;
         media_locked <= 1'b0;
         look_ahead_en <= feature_pkg::DEF_RLA;
         release_irq_en <= 1'b0;
         service_irq_en <= 1'b0;
         revert_en <= hard_rst ? feature_pkg::DEF_REVERT : revert_en;
      end else if (exec_ok) begin
         case (features)
            feature_pkg::SUB_BYTE_ON: byte_mode <= 1'b1;
            feature_pkg::SUB_BYTE_OFF: byte_mode <= 1'b0;
            feature_pkg::SUB_WC_ON: write_cache_en <= 1'b1;
            feature_pkg::SUB_WC_OFF: write_cache_en <= 1'b0;
            feature_pkg::SUB_APM_ON: begin
               apm_en <= 1'b1;
               apm_level <= sector_count;
            end
            feature_pkg::SUB_APM_OFF: apm_en <= 1'b0;
            feature_pkg::SUB_HIPWR: low_power <= 1'b0;
            feature_pkg::SUB_LOPWR: low_power <= 1'b1;
            feature_pkg::SUB_MSN_OFF: begin
               // already off: both bits are already clear, so nothing changes
               notify_en <= 1'b0;
               media_locked <= 1'b0;
            end
            feature_pkg::SUB_MSN_ON: begin
               notify_en <= 1'b1;
               media_locked <= 1'b0;
            end
            feature_pkg::SUB_RLA_ON: look_ahead_en <= 1'b1;
            feature_pkg::SUB_RLA_OFF: look_ahead_en <= 1'b0;
            feature_pkg::SUB_REL_ON: release_irq_en <= 1'b1;
            feature_pkg::SUB_REL_OFF: release_irq_en <= 1'b0;
            feature_pkg::SUB_SVC_ON: service_irq_en <= 1'b1;
            feature_pkg::SUB_SVC_OFF: service_irq_en <= 1'b0;
            feature_pkg::SUB_REVERT_ON: revert_en <= 1'b1;
            feature_pkg::SUB_REVERT_OFF: revert_en <= 1'b0;
            default: revert_en <= revert_en;
         endcase
      end
   end

   // transfer mode; a rejected request never reaches here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pio_mode <= 3'h0;
         iordy_off <= 1'b0;
         dma_family <= feature_pkg::FAM_NONE;
         dma_mode <= 3'h0;
      end else if (revert_now) begin
         pio_mode <= 3'h0;
         iordy_off <= 1'b0;
         dma_family <= feature_pkg::FAM_NONE;
         dma_mode <= 3'h0;
      end else if (set_xfer) begin
         case (xfer_type)
            feature_pkg::XT_DEFAULT: begin
               pio_mode <= 3'h0;
               iordy_off <= (xfer_num == feature_pkg::NUM_NO_IORDY);
            end
            feature_pkg::XT_PIO: begin
               pio_mode <= xfer_num;
               iordy_off <= 1'b0;
            end
            feature_pkg::XT_MWDMA: begin
               dma_family <= feature_pkg::FAM_MWDMA;
               dma_mode <= xfer_num;
            end
            feature_pkg::XT_UDMA: begin
               dma_family <= feature_pkg::FAM_UDMA;
               dma_mode <= xfer_num;
            end
            default: pio_mode <= pio_mode;
         endcase
      end
   end
   assign iordy_active = !iordy_off || (pio_mode >= feature_pkg::PIO_IORDY_MIN);
   assign apm_standby_ok = apm_en && (apm_level < feature_pkg::APM_NO_SPINDOWN);

   // notification outputs latched on the enabling subcommand
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         notify_version <= 8'h00;
         notify_capability <= 8'h00;
      end else if (exec_ok && features == feature_pkg::SUB_MSN_ON) begin
         notify_version <= feature_pkg::NOTIFY_VERSION;
         notify_capability <= {5'h00, feature_pkg::EJECT_CAPABLE, feature_pkg::LOCK_CAPABLE, notify_en};
      end
   end

   // checks
   sequence s_run(logic [7:0] code);
      state == S_EXEC && !bad && features == code;
   endsequence
   sequence s_reject;
      state == S_EXEC && bad;
   endsequence

   a_wc_flush_busy: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_WC_OFF) ##0 (!hard_rst && !soft_rst) |=> !write_cache_en && flush_req && busy)
      else $error("write cache disable did not start flush");
   a_abort_flags: assert property (@(posedge pclk) disable iff (!presetn)
      s_reject ##0 (!hard_rst && !soft_rst) |=> err && abrt && !busy)
      else $error("abort did not set error flags");
   a_mode_kept: assert property (@(posedge pclk) disable iff (!presetn)
      s_reject ##0 (!revert_now) |=> $stable(pio_mode) && $stable(dma_mode) && $stable(dma_family))
      else $error("rejected request changed transfer mode");
   a_udma_selects: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_XFER) ##0 (xfer_type == feature_pkg::XT_UDMA && !revert_now)
      |=> dma_family == feature_pkg::FAM_UDMA && dma_mode == $past(xfer_num))
      else $error("ultra dma selection not applied");
   a_iordy_high_pio: assert property (@(posedge pclk) disable iff (!presetn)
      pio_mode >= feature_pkg::PIO_IORDY_MIN |-> iordy_active)
      else $error("IORDY off in high pio mode");
   a_apm_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      state == S_EXEC && features == feature_pkg::SUB_APM_ON && !apm_good && !revert_now
      |=> abrt && $stable(apm_level))
      else $error("reserved power level accepted");
   a_puis_persist: assert property (@(posedge pclk) disable iff (!presetn)
      hard_rst || soft_rst |=> puis_en == $past(puis_en))
      else $error("standby power-up setting lost on reset");
   a_hard_hipower: assert property (@(posedge pclk) disable iff (!presetn)
      hard_rst |=> !low_power ##1 !busy)
      else $error("hardware reset left low power mode");
   a_notify_cap: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_MSN_ON) ##0 !revert_now
      |=> notify_capability[7:3] == 5'h00 && notify_capability[0] == $past(notify_en) && notify_en)
      else $error("notification capability byte wrong");
   a_low_power_gate: assert property (@(posedge pclk) disable iff (!presetn)
      state == S_EXEC && low_power && !pwr_sub |=> abrt)
      else $error("low power accepted a forbidden subcommand");
   a_mwdma_selects: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_XFER) ##0 (xfer_type == feature_pkg::XT_MWDMA && !revert_now)
      |=> dma_family == feature_pkg::FAM_MWDMA && dma_mode == $past(xfer_num))
      else $error("multiword dma selection not applied");
   a_flush_hold: assert property (@(posedge pclk) disable iff (!presetn)
      state == S_FLUSH && !flush_done && !hard_rst && !soft_rst |=> busy && flush_req)
      else $error("command completed before flush finished");
   a_flush_frees: assert property (@(posedge pclk) disable iff (!presetn)
      state == S_FLUSH && flush_done && !hard_rst && !soft_rst |=> !busy && !flush_req)
      else $error("flush finish did not complete the command");
   a_apm_level_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_APM_ON) ##0 !revert_now
      |=> apm_en && apm_level == $past(sector_count))
      else $error("power management level not taken");
   a_spinup_active: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_SPINUP) ##0 (!hard_rst && !soft_rst) |=> !in_standby)
      else $error("spin-up left the device in standby");
   a_soft_keep: assert property (@(posedge pclk) disable iff (!presetn)
      soft_rst && !revert_en && !hard_rst && state != S_EXEC |=> $stable(look_ahead_en) && $stable(low_power))
      else $error("software reset reverted settings while reverting was off");
   a_msn_off: assert property (@(posedge pclk) disable iff (!presetn)
      s_run(feature_pkg::SUB_MSN_OFF) ##0 !revert_now |=> !notify_en && !media_locked)
      else $error("notification disable left notification or lock on");
endmodule
`default_nettype wire

// >>> sim/flush_model.sv
`timescale 1ns/10ps
`default_nettype none
module flush_model #(
   parameter int DELAY = 6
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // flush handshake
   input wire logic flush_req,
   output logic flush_done
);
   int cnt;
   // a slow cache: done only after DELAY+1 cycles, dropped after one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         flush_done <= 1'h0;
      end else if (flush_req && !flush_done) begin
         cnt <= cnt + 1;
         flush_done <= (cnt == DELAY);
      end else begin
         cnt <= 0;
         flush_done <= 1'h0;
      end
   end
endmodule
`default_nettype wire

// >>> sim/tb_set_features_subcommand_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tb_set_features_subcommand_unit;
   typedef struct {logic [7:0] f, s, a; logic [15:0] m, e; logic ab;} row_s;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, flush_req, flush_done, se, sok, saw_flush = 1'h0;
   int bad_count = 0, tests_run = 0, cyc = 0;
   // f, s, read address, mask, expected, aborted
   row_s rows[$] = '{'{8'h02,8'h00,8'h18,16'h0800,16'h0800,1'h0},
      '{8'h03,8'h0C,8'h1C,16'h00FF,16'h0004,1'h0}, '{8'h03,8'h0B,8'h18,16'h0004,16'h0004,1'h0},
      '{8'h03,8'h01,8'h18,16'h2004,16'h2000,1'h0}, '{8'h03,8'h22,8'h1C,16'h00C0,16'h0040,1'h0},
      '{8'h03,8'h45,8'h1C,16'h00F8,16'h00A8,1'h0}, '{8'h03,8'h10,8'h1C,16'h00F8,16'h00A8,1'h1},
      '{8'h03,8'h46,8'h1C,16'h00F8,16'h00A8,1'h1}, '{8'h05,8'h7F,8'h20,16'h00FF,16'h007F,1'h0},
      '{8'h05,8'hFF,8'h20,16'h00FF,16'h007F,1'h1}, '{8'h85,8'h00,8'h18,16'h0400,16'h0000,1'h0},
      '{8'h95,8'h00,8'h14,16'h00FF,16'h0002,1'h0}, '{8'h95,8'h00,8'h14,16'h00FF,16'h0003,1'h0},
      '{8'h95,8'h00,8'h10,16'h00FF,16'h0000,1'h0}, '{8'h31,8'h00,8'h18,16'h00C0,16'h0000,1'h0},
      '{8'h31,8'h00,8'h18,16'h00C0,16'h0000,1'h0}, '{8'h55,8'h00,8'h18,16'h0020,16'h0000,1'h0},
      '{8'hAA,8'h00,8'h18,16'h0020,16'h0020,1'h0}, '{8'h5D,8'h00,8'h18,16'h0010,16'h0010,1'h0},
      '{8'h5E,8'h00,8'h18,16'h0008,16'h0008,1'h0}, '{8'hDE,8'h00,8'h18,16'h0008,16'h0000,1'h0},
      '{8'h8A,8'h00,8'h18,16'h0100,16'h0100,1'h0}, '{8'h02,8'h00,8'h18,16'h0100,16'h0100,1'h1},
      '{8'h0A,8'h00,8'h18,16'h0100,16'h0000,1'h0}, '{8'h01,8'h00,8'h18,16'h1000,16'h1000,1'h0},
      '{8'h81,8'h00,8'h18,16'h1000,16'h0000,1'h0}, '{8'h86,8'h00,8'h18,16'h8000,16'h0000,1'h0},
      '{8'h06,8'h00,8'h18,16'h8000,16'h8000,1'h0}, '{8'hF0,8'h00,8'h18,16'h0000,16'h0000,1'h1}};

   set_features_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flush_req(flush_req), .flush_done(flush_done), .byte_mode(),
      .write_cache_en(), .iordy_active(), .pio_mode(), .dma_family(), .dma_mode(), .apm_en(),
      .apm_standby_ok(sok), .in_standby(), .low_power(), .notify_en(), .media_locked(),
      .look_ahead_en(), .release_irq_en(), .service_irq_en());
   flush_model i_cache (.pclk(pclk), .presetn(presetn), .flush_req(flush_req), .flush_done(flush_done));

   initial begin
      forever #5 pclk = ~pclk;
   end
   // hang guard: the whole run needs under a thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      saw_flush <= saw_flush | flush_req;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // issue the command and poll until busy clears
   task automatic cmd(input logic [7:0] f, input logic [7:0] s);
      apb(1'h1, feature_pkg::ADDR_FEATURES, {24'h0, f});
      apb(1'h1, feature_pkg::ADDR_SECTOR_COUNT, {24'h0, s});
      apb(1'h1, feature_pkg::ADDR_COMMAND, {24'h0, feature_pkg::CMD_SET_FEATURES});
      do apb(1'h0, feature_pkg::ADDR_STATUS, 32'h0); while (rd[7] !== 1'h0);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd & {16'h0, m}, {16'h0, e});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      rchk(8'h1C, 16'h00FF, 16'h0000);
      rchk(8'h18, 16'h8824, 16'h0824);
      foreach (rows[i]) begin
         cmd(rows[i].f, rows[i].s);
         chk(rd & 32'hD1, rows[i].ab ? 32'h51 : 32'h40);
         rchk(rows[i].a, rows[i].m, rows[i].e);
      end
      cmd(8'h05, 8'h80);
      chk({31'h0, sok}, 32'h0);
      cmd(8'h05, 8'h7F);
      chk({31'h0, sok}, 32'h1);
      cmd(8'h82, 8'h00);
      chk({31'h0, saw_flush}, 32'h1);
      rchk(8'h18, 16'h0800, 16'h0000);
      apb(1'h1, feature_pkg::ADDR_RESET_CTRL, 32'h2);
      rchk(8'h18, 16'h8A00, 16'h8A00);
      cmd(8'h07, 8'h00);
      rchk(8'h18, 16'h0200, 16'h0000);
      cmd(8'h66, 8'h00);
      cmd(8'h55, 8'h00);
      apb(1'h1, feature_pkg::ADDR_RESET_CTRL, 32'h1);
      rchk(8'h18, 16'h0020, 16'h0000);
      cmd(8'hCC, 8'h00);
      apb(1'h1, feature_pkg::ADDR_RESET_CTRL, 32'h1);
      rchk(8'h18, 16'h0020, 16'h0020);
      // unmapped word: error response and zero data
      apb(1'h0, 8'hFC, 32'h0);
      chk({se, rd[30:0]}, 32'h80000000);
      wrap_up();
   end
endmodule
`default_nettype wire
